//--- bench/tb_tro_trig_cmd.sv
// Purpose: self-checking bench of the trigger/resolution opcode block
// Assumes: host model does the bus work, bench keeps the expected setup
// Notes:   random values come from an xorshift seeded with 32'h2D21
module tb_tro_trig_cmd;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_busy, sub_en;
  logic [31:0] haddr, hwdata, hrdata, q, p, seed = 32'h2D21;
  logic [1:0] htrans, edge_mode, edge_lsb;
  logic [2:0] hsize, lead_res;
  logic [3:0] width_res;
  logic [11:0] win_width, win_offset, extra_margin, reject_margin;
  logic [15:0] w, o;
  int n_errors = 0, comparisons = 0;
  // defaults: 0x14 width, 0xFFD8 offset, 8 and 4 margins, leading, 100 ps
  localparam tro_pkg::tro_cfg_s RST_CFG = '{12'h014, 12'hFD8, 12'h008,
    12'h004, 1'b0, 2'h2, 2'h2, 3'h0, 4'h0};
  tro_pkg::tro_cfg_s ex;

  tro_trig_cmd DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .win_width(win_width),
    .win_offset(win_offset), .extra_margin(extra_margin),
    .reject_margin(reject_margin), .sub_en(sub_en), .edge_mode(edge_mode),
    .edge_lsb(edge_lsb), .lead_res(lead_res), .width_res(width_res),
    .cmd_busy(cmd_busy));
  tro_host u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected readback words, offset sign-extended
  function automatic logic [15:0] exp_word(input logic [7:0] op, int i);
    if (op == 8'h23) return {14'h0, ex.edge_mode};
    if (op == 8'h26) return (ex.edge_mode == 2'b00) ?
      {4'h0, ex.width_res, 5'h0, ex.lead_res} : {14'h0, ex.edge_lsb};
    case (i)
      0: return {4'h0, ex.width};
      1: return {{4{ex.offset[11]}}, ex.offset};
      2: return {4'h0, ex.extra};
      3: return {4'h0, ex.reject};
      default: return {15'h0, ex.sub_en};
    endcase
  endfunction

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // setup outputs compared once the edge updates have landed
  task automatic chk_cfg();
    tro_pkg::tro_cfg_s got;
    #1;
    got = {win_width, win_offset, extra_margin, reject_margin, sub_en,
           edge_mode, edge_lsb, lead_res, width_res};
    comparisons++;
    if (got !== ex || cmd_busy !== 1'b0 || hresp !== 1'b0) begin
      n_errors++;
      $display("[ERR] %0t setup %h expected %h", $time, got, ex);
    end
  endtask

  // opcode with random low byte, then its one parameter word
  task automatic set(input logic [7:0] op, input logic [15:0] v);
    u_host.xfer(1'b1, 8'h00, {16'h0, op, 8'(xs())}, q);
    #1 chk_word({15'h0, cmd_busy}, 16'h0001);
    u_host.xfer(1'b1, 8'h00, {16'(xs()), v}, q);
  endtask

  // readback opcode; a stray opcode while words are owed must be dropped
  task automatic rb(input logic [7:0] op, input int n);
    u_host.xfer(1'b1, 8'h00, {16'h0, op, 8'(xs())}, q);
    u_host.xfer(1'b1, 8'h00, 32'h0000_1000, q);
    u_host.xfer(1'b0, 8'h04, 32'h0, q);
    chk_word(q[15:0], 16'h0006);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(1'b0, 8'h00, 32'h0, q);
      chk_word(q[15:0], exp_word(op, i));
    end
  endtask

  task automatic give_verdict();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // run needs about 1100 cycles; reaching the 10,000-cycle limit means a hang
  initial begin
    #500_000;
    n_errors++;
    give_verdict();
  end

  initial begin
    ex = RST_CFG;
    for (int r = 0; r < 2; r++) begin
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ex = RST_CFG;
      chk_cfg();
      rb(8'h16, 5);
    end
    u_host.xfer(1'b0, 8'h00, 32'h0, q);
    chk_word(q[15:0], 16'h0000);
    // window: zero width dropped, range ends, then random
    for (int i = 0; i < 8; i++) begin
      p = xs();
      w = (i == 0) ? 16'hF000 : (i == 1) ? 16'h0FFF : p[15:0];
      o = (i == 0) ? 16'hF800 : (i == 1) ? 16'h0028 :
          16'(-2048 + int'(p % 2089));
      set(8'h10, w);
      if (w[11:0] != 12'h0) ex.width = w[11:0];
      set(8'h11, o);
      ex.offset = o[11:0];
      set(8'h12, p[31:16]);
      ex.extra = p[27:16];
      set(8'h13, ~p[31:16]);
      ex.reject = ~p[27:16];
      chk_cfg();
      rb(8'h16, 5);
    end
    for (int s = 1; s >= 0; s--) begin
      u_host.xfer(1'b1, 8'h00, {16'h0, s ? 8'h14 : 8'h15, 8'(xs())}, q);
      ex.sub_en = s[0];
      chk_cfg();
      rb(8'h16, 5);
    end
    for (int m = 0; m < 4; m++) begin
      p = xs();
      set(8'h22, {p[15:2], 2'(m)});
      ex.edge_mode = 2'(m);
      chk_cfg();
      rb(8'h23, 1);
      rb(8'h26, 1);
    end
    for (int c = 0; c < 4; c++) begin
      set(8'h24, {14'h0, 2'(c)});
      if (c != 3) ex.edge_lsb = 2'(c);
      chk_cfg();
      rb(8'h26, 1);
    end
    // pair mode first, then every width code with junk in loose bits
    set(8'h22, 16'h0000);
    ex.edge_mode = 2'b00;
    for (int k = 0; k < 16; k++) begin
      p = xs();
      w = {p[15:12], 4'(k), p[7:0]};
      set(8'h25, w);
      ex.lead_res = w[2:0];
      if (k < 14) ex.width_res = 4'(k);
      chk_cfg();
      rb(8'h26, 1);
    end
    // reset mid-run with a changed setup and readback words still owed
    u_host.xfer(1'b1, 8'h00, {16'h0, 8'h16, 8'(xs())}, q);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ex = RST_CFG;
    chk_cfg();
    u_host.xfer(1'b0, 8'h00, 32'h0, q);
    chk_word(q[15:0], 16'h0000);
    give_verdict();
  end
endmodule // tb_tro_trig_cmd

//--- bench/tro_host.sv
// Purpose: host model, an AHB-Lite master issuing opcodes and words
// Assumes: one slave, whose hreadyout is the bus hready
// Notes:   single word transfers; only the bench watchdog ends a wait
module tro_host (
  input logic hclk,
  input logic hreadyout,
  input logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // address phase held until taken, then data phase until hready
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~d;
  endtask
endmodule // tro_host

//--- src/tro_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the opcode registers
// Assumes: single word transfers, response always OKAY
// Notes:   writes take no wait state, reads take exactly one
module tro_ahb_slave (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  tro_reg_if.slave rif
);

  typedef struct packed {
    logic dph;
    logic dwrite;
    logic [7:0] daddr;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
  } tro_ahb_s;

  localparam tro_ahb_s AHB_RST = '{dph: 1'b0, dwrite: 1'b0, daddr: 8'h00,
    rdy: 1'b1, resp: 1'b0, rdata: 32'h0000_0000};

  tro_ahb_s s_r;
  tro_ahb_s s_nxt;
  logic take;
  logic unused_size;

  // ----------------------------------------------------------------------
  // strobes toward the core
  // ----------------------------------------------------------------------
  // read data is sampled a cycle late so the readback word has settled
  assign rif.wr_en = s_r.dph & s_r.dwrite;
  assign rif.rd_en = s_r.dph & ~s_r.dwrite & ~s_r.rdy;
  assign rif.addr = s_r.daddr;
  assign rif.wdata = hwdata;
  assign take = hready & hsel & htrans[1];
  assign unused_size = ^hsize; // word transfers only

  // next state of the bus phases
  always_comb begin
    s_nxt = s_r;
    if (rif.rd_en) begin
      s_nxt.rdata = rif.rdata;
      s_nxt.rdy = 1'b1;
    end else if (hready) begin
      s_nxt.dph = take;
      s_nxt.dwrite = hwrite;
      s_nxt.daddr = haddr[7:0];
      s_nxt.rdy = ~(take & ~hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= AHB_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.rdy;
  assign hresp = s_r.resp;
  assign hrdata = s_r.rdata;

endmodule // tro_ahb_slave

//--- src/tro_pkg.sv
// Purpose: shared constants and types of the trigger/resolution opcode block
// Assumes: AHB-Lite word registers, 16-bit opcode and parameter words
// Notes:   window figures count cycles of the 25 ns acquisition clock
package tro_pkg;

  // ----------------------------------------------------------------------
  // register map and status bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MICRO = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int unsigned ST_WR_RDY_BIT = 0;
  localparam int unsigned ST_RD_RDY_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 2;

  // ----------------------------------------------------------------------
  // opcodes, high byte of the command word
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_SET_WIDTH = 8'h10;
  localparam logic [7:0] OP_SET_OFFSET = 8'h11;
  localparam logic [7:0] OP_SET_EXTRA = 8'h12;
  localparam logic [7:0] OP_SET_REJECT = 8'h13;
  localparam logic [7:0] OP_SUB_ON = 8'h14;
  localparam logic [7:0] OP_SUB_OFF = 8'h15;
  localparam logic [7:0] OP_READ_TRIG = 8'h16;
  localparam logic [7:0] OP_SET_EDGE = 8'h22;
  localparam logic [7:0] OP_READ_EDGE = 8'h23;
  localparam logic [7:0] OP_SET_LSB = 8'h24;
  localparam logic [7:0] OP_SET_PAIR = 8'h25;
  localparam logic [7:0] OP_READ_RES = 8'h26;

  // ----------------------------------------------------------------------
  // field positions, word counts, codes
  // ----------------------------------------------------------------------
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned LEAD_RES_LSB = 0;
  localparam int unsigned WIDTH_RES_LSB = 8;
  localparam logic [2:0] PARAM_WORDS = 3'd1;
  localparam logic [2:0] TRIG_RB_WORDS = 3'd5;
  localparam logic [2:0] ONE_RB_WORDS = 3'd1;
  localparam logic [3:0] WIDTH_RES_MAX = 4'hD;
  localparam logic [1:0] EDGE_PAIR = 2'h0;
  localparam logic [1:0] EDGE_LSB_UNUSED = 2'h3;
  localparam int unsigned ACQ_CLK_PERIOD_NS = 25;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [11:0] WIDTH_RST = 12'h014;
  localparam logic [11:0] OFFSET_RST = 12'hFD8;
  localparam logic [11:0] EXTRA_RST = 12'h008;
  localparam logic [11:0] REJECT_RST = 12'h004;
  localparam logic [1:0] EDGE_MODE_RST = 2'h2;
  localparam logic [1:0] EDGE_LSB_RST = 2'h2;
  localparam logic [2:0] LEAD_RES_RST = 3'h0;
  localparam logic [3:0] WIDTH_RES_RST = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_WR = 2'b01,
    ST_WAIT_RD = 2'b10
  } tro_state_e;

  typedef struct packed {
    logic [11:0] width;
    logic [11:0] offset;
    logic [11:0] extra;
    logic [11:0] reject;
    logic sub_en;
    logic [1:0] edge_mode;
    logic [1:0] edge_lsb;
    logic [2:0] lead_res;
    logic [3:0] width_res;
  } tro_cfg_s;

  localparam tro_cfg_s CFG_RST = '{
    width: WIDTH_RST, offset: OFFSET_RST, extra: EXTRA_RST,
    reject: REJECT_RST, sub_en: 1'b0, edge_mode: EDGE_MODE_RST,
    edge_lsb: EDGE_LSB_RST, lead_res: LEAD_RES_RST,
    width_res: WIDTH_RES_RST};

endpackage

//--- src/tro_readback.sv
// Purpose: selects and registers the 16-bit readback word
// Assumes: driven with the next core state, so the word tracks the current
// Notes:   unknown opcodes read as zero
module tro_readback (
  input logic hclk,
  input logic hresetn,
  input logic [7:0] op,
  input logic [2:0] idx,
  input tro_pkg::tro_cfg_s cfg,
  output logic [15:0] rb_word
);

  typedef struct packed {
    logic [15:0] word;
  } tro_rb_s;

  tro_rb_s s_r;
  tro_rb_s s_nxt;

  // ----------------------------------------------------------------------
  // word select
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt.word = 16'h0000;
    case (op)
      tro_pkg::OP_READ_TRIG: begin
        case (idx)
          3'd0: s_nxt.word = {4'h0, cfg.width};
          3'd1: s_nxt.word = {{4{cfg.offset[11]}}, cfg.offset};
          3'd2: s_nxt.word = {4'h0, cfg.extra};
          3'd3: s_nxt.word = {4'h0, cfg.reject};
          3'd4: s_nxt.word = {15'h0000, cfg.sub_en};
          default: s_nxt.word = 16'h0000;
        endcase
      end
      tro_pkg::OP_READ_EDGE: s_nxt.word = {14'h0000, cfg.edge_mode};
      tro_pkg::OP_READ_RES: begin
        if (cfg.edge_mode == tro_pkg::EDGE_PAIR) begin
          s_nxt.word = {4'h0, cfg.width_res, 5'h00, cfg.lead_res};
        end else begin
          s_nxt.word = {14'h0000, cfg.edge_lsb};
        end
      end
      default: s_nxt.word = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rb_word = s_r.word;

endmodule // tro_readback

//--- src/tro_reg_if.sv
// Purpose: register access strobes between bus slave and opcode core
// Assumes: one clock, strobes last one cycle
// Notes:   rdata is combinational from the core, registered by the slave
interface tro_reg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output wr_en, output rd_en, output addr, output wdata,
                 input rdata);
  modport core (input wr_en, input rd_en, input addr, input wdata,
                output rdata);
endinterface

//--- src/tro_trig_cmd.sv
// Purpose: opcode interpreter for match window and tdc resolution setup
// Assumes: host issues opcodes and parameter words at the command word
// Notes:   a second opcode is not decoded while parameter words are owed
module tro_trig_cmd (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [11:0] win_width,
  output logic [11:0] win_offset,
  output logic [11:0] extra_margin,
  output logic [11:0] reject_margin,
  output logic sub_en,
  output logic [1:0] edge_mode,
  output logic [1:0] edge_lsb,
  output logic [2:0] lead_res,
  output logic [3:0] width_res,
  output logic cmd_busy
);

  typedef struct packed {
    tro_pkg::tro_state_e st;
    logic [7:0] op;
    logic [2:0] cnt;
    logic [2:0] idx;
    tro_pkg::tro_cfg_s cfg;
    logic busy;
  } tro_core_s;

  localparam tro_core_s CORE_RST = '{st: tro_pkg::ST_IDLE, op: 8'h00,
    cnt: 3'd0, idx: 3'd0, cfg: tro_pkg::CFG_RST, busy: 1'b0};

  tro_core_s s_r;
  tro_core_s s_nxt;
  tro_reg_if rif ();
  logic [15:0] rb_word;
  logic wr_micro;
  logic rd_micro;
  logic [7:0] opc;
  logic [15:0] prm;
  logic [2:0] status;

  // ----------------------------------------------------------------------
  // bus front end and readback word
  // ----------------------------------------------------------------------
  tro_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif)
  );

  // fed from the next state: a read right after the opcode sees a fresh word
  tro_readback u_rb (
    .hclk(hclk),
    .hresetn(hresetn),
    .op(s_nxt.op),
    .idx(s_nxt.idx),
    .cfg(s_nxt.cfg),
    .rb_word(rb_word)
  );

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  assign wr_micro = rif.wr_en & (rif.addr == tro_pkg::ADDR_MICRO);
  assign rd_micro = rif.rd_en & (rif.addr == tro_pkg::ADDR_MICRO);
  assign opc = rif.wdata[tro_pkg::OPC_LSB +: 8];
  assign prm = rif.wdata[15:0];

  // status lets software poll before the next opcode or word
  always_comb begin
    status = 3'b000;
    status[tro_pkg::ST_WR_RDY_BIT] = (s_r.st != tro_pkg::ST_WAIT_RD);
    status[tro_pkg::ST_RD_RDY_BIT] = (s_r.st == tro_pkg::ST_WAIT_RD);
    status[tro_pkg::ST_BUSY_BIT] = (s_r.st != tro_pkg::ST_IDLE);
  end

  // read mux, command word reads zero unless a readback is owed
  always_comb begin
    case (rif.addr)
      tro_pkg::ADDR_MICRO: begin
        rif.rdata = 32'h0000_0000;
        if (s_r.st == tro_pkg::ST_WAIT_RD) begin
          rif.rdata = {16'h0000, rb_word};
        end
      end
      tro_pkg::ADDR_STATUS: rif.rdata = {29'h0000_0000, status};
      default: rif.rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // opcode interpreter
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      tro_pkg::ST_IDLE: begin
        if (wr_micro) begin
          s_nxt.op = opc;
          s_nxt.idx = 3'd0;
          case (opc)
            // width and other setters wait for a word
            tro_pkg::OP_SET_WIDTH, tro_pkg::OP_SET_OFFSET,
            tro_pkg::OP_SET_EXTRA, tro_pkg::OP_SET_REJECT,
            tro_pkg::OP_SET_EDGE, tro_pkg::OP_SET_LSB,
            tro_pkg::OP_SET_PAIR: begin
              s_nxt.st = tro_pkg::ST_WAIT_WR;
              s_nxt.cnt = tro_pkg::PARAM_WORDS;
            end
            tro_pkg::OP_SUB_ON: s_nxt.cfg.sub_en = 1'b1;
            tro_pkg::OP_SUB_OFF: s_nxt.cfg.sub_en = 1'b0;
            tro_pkg::OP_READ_TRIG: begin
              s_nxt.st = tro_pkg::ST_WAIT_RD;
              s_nxt.cnt = tro_pkg::TRIG_RB_WORDS;
            end
            tro_pkg::OP_READ_EDGE, tro_pkg::OP_READ_RES: begin
              s_nxt.st = tro_pkg::ST_WAIT_RD;
              s_nxt.cnt = tro_pkg::ONE_RB_WORDS;
            end
            default: s_nxt.op = s_r.op; // unknown opcodes ignored
          endcase
        end
      end
      tro_pkg::ST_WAIT_WR: begin
        if (wr_micro) begin
          case (s_r.op)
            // zero is outside the legal width range, kept out
            tro_pkg::OP_SET_WIDTH: begin
              if (prm[11:0] != 12'h000) begin
                s_nxt.cfg.width = prm[11:0];
              end
            end
            // signed cycles, sign bits above 11 dropped
            tro_pkg::OP_SET_OFFSET: s_nxt.cfg.offset = prm[11:0];
            tro_pkg::OP_SET_EXTRA: s_nxt.cfg.extra = prm[11:0];
            tro_pkg::OP_SET_REJECT: s_nxt.cfg.reject = prm[11:0];
            tro_pkg::OP_SET_EDGE: s_nxt.cfg.edge_mode = prm[1:0];
            // unused code leaves the setting alone
            tro_pkg::OP_SET_LSB: begin
              if (prm[1:0] != tro_pkg::EDGE_LSB_UNUSED) begin
                s_nxt.cfg.edge_lsb = prm[1:0];
              end
            end
            tro_pkg::OP_SET_PAIR: begin
              s_nxt.cfg.lead_res = prm[tro_pkg::LEAD_RES_LSB +: 3];
              if (prm[tro_pkg::WIDTH_RES_LSB +: 4] <=
                  tro_pkg::WIDTH_RES_MAX) begin
                s_nxt.cfg.width_res = prm[tro_pkg::WIDTH_RES_LSB +: 4];
              end
            end
            default: s_nxt.cfg = s_r.cfg;
          endcase
          if (s_r.idx == s_r.cnt - 3'd1) begin
            s_nxt.st = tro_pkg::ST_IDLE;
            s_nxt.idx = 3'd0;
          end else begin
            s_nxt.idx = s_r.idx + 3'd1;
          end
        end
      end
      tro_pkg::ST_WAIT_RD: begin
        // stall until every word is read
        if (rd_micro) begin
          if (s_r.idx == s_r.cnt - 3'd1) begin
            s_nxt.st = tro_pkg::ST_IDLE;
            s_nxt.idx = 3'd0;
          end else begin
            s_nxt.idx = s_r.idx + 3'd1;
          end
        end
      end
      default: s_nxt.st = tro_pkg::ST_IDLE;
    endcase
    // busy kept in a flop so the output is registered
    s_nxt.busy = (s_nxt.st != tro_pkg::ST_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // configuration outputs straight from the state register
  assign win_width = s_r.cfg.width;
  assign win_offset = s_r.cfg.offset;
  assign extra_margin = s_r.cfg.extra;
  assign reject_margin = s_r.cfg.reject;
  assign sub_en = s_r.cfg.sub_en;
  assign edge_mode = s_r.cfg.edge_mode;
  assign edge_lsb = s_r.cfg.edge_lsb;
  assign lead_res = s_r.cfg.lead_res;
  assign width_res = s_r.cfg.width_res;
  assign cmd_busy = s_r.busy;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_idle_op(logic [7:0] o);
    s_r.st == tro_pkg::ST_IDLE && wr_micro && opc == o;
  endsequence

  sequence s_param(logic [7:0] o);
    s_r.st == tro_pkg::ST_WAIT_WR && wr_micro && s_r.op == o;
  endsequence

  a_width_wait: assert property (
    s_idle_op(tro_pkg::OP_SET_WIDTH) ##1 !wr_micro [*3]
    |-> s_r.st == tro_pkg::ST_WAIT_WR && cmd_busy)
    else $error("width opcode did not wait for its word");

  a_width_load: assert property (
    s_param(tro_pkg::OP_SET_WIDTH) and prm[11:0] != 12'h000
    |=> win_width == $past(prm[11:0]) && !cmd_busy)
    else $error("width not taken from low twelve bits");

  a_offset_load: assert property (
    s_param(tro_pkg::OP_SET_OFFSET)
    |=> win_offset == $past(prm[11:0]))
    else $error("offset not stored");

  a_extra_load: assert property (
    s_param(tro_pkg::OP_SET_EXTRA) |=> extra_margin == $past(prm[11:0]))
    else $error("extra margin not stored");

  a_reject_load: assert property (
    s_param(tro_pkg::OP_SET_REJECT) |=> reject_margin == $past(prm[11:0]))
    else $error("reject margin not stored");

  a_sub_set: assert property (
    s_idle_op(tro_pkg::OP_SUB_ON) |=> sub_en ##1 sub_en || $past(wr_micro))
    else $error("subtraction not enabled");

  a_sub_clear: assert property (
    s_idle_op(tro_pkg::OP_SUB_OFF) |=> !sub_en && !cmd_busy)
    else $error("subtraction not disabled");

  a_trig_words: assert property (
    s_idle_op(tro_pkg::OP_READ_TRIG)
    |=> s_r.st == tro_pkg::ST_WAIT_RD && s_r.cnt == 3'd5 && s_r.idx == 3'd0
    && rb_word == {4'h0, win_width})
    else $error("trigger readback not set up");

  a_edge_load: assert property (
    s_param(tro_pkg::OP_SET_EDGE) |=> edge_mode == $past(prm[1:0]))
    else $error("edge mode not stored");

  a_lsb_unused: assert property (
    s_param(tro_pkg::OP_SET_LSB) and prm[1:0] == 2'h3 |=> $stable(edge_lsb))
    else $error("unused lsb code changed setting");

  a_pair_invalid: assert property (
    s_param(tro_pkg::OP_SET_PAIR) and prm[11:8] > 4'hD
    |=> $stable(width_res) && lead_res == $past(prm[2:0]))
    else $error("invalid width resolution code taken");

  a_res_word: assert property (
    s_r.st == tro_pkg::ST_WAIT_RD && s_r.op == tro_pkg::OP_READ_RES &&
    $stable(s_r.cfg) && $stable(s_r.op)
    |-> rb_word == (edge_mode == 2'h0 ?
        {4'h0, width_res, 5'h00, lead_res} : {14'h0000, edge_lsb}))
    else $error("resolution readback word wrong");

  a_read_stall: assert property (
    s_r.st == tro_pkg::ST_WAIT_RD && !rd_micro
    |=> s_r.st == tro_pkg::ST_WAIT_RD && $stable(s_r.op))
    else $error("readback wait left early");

  a_low_byte: assert property (
    s_r.st == tro_pkg::ST_IDLE && wr_micro &&
    prm[15:8] == 8'h10 && prm[7:0] != 8'h00
    |=> s_r.st == tro_pkg::ST_WAIT_WR)
    else $error("low byte changed opcode decode");

endmodule // tro_trig_cmd
